// File: hw/fdr_requester.sv
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: Byte length is twice sample size
// R2: Size split evenly over active channels
// R3: Start address signed, zero at trigger
// R4: Round address down by channel resolution
// R5: Immediate command issues one request per group
// R6: Immediate refused in auto mode, flag error
// R7: Report immediate only while transfer outstanding
// R8: Auto request on measurement complete after arm
// R9: Continuous: request per acquired block
// R10: Halt acquisition while no buffer free
// R11: Mark LSB before overrun when enabled
// R12: Continuous address starts at trigger, advances
// R13: Auto size rounds up to power two
// R14: Off command disables both modes
// R15: Query returns state, size, address
// R16: Response route switches immediately
// R17: Queue query returns filled buffer count
// R18: Defaults size 16384, address zero, list 1
// R19: Routing change resets size and address
// R20: Hardware channel n maps to group n+1
// R21: Request held until done, then next
module fdr_requester
   import fdr_pkg::*;
#(
   parameter int QDEPTH = fdr_pkg::QUEUE_DEPTH
)
(
   input  wire logic                             ref_clk,
   input  wire logic                             rstn,
   input  wire fdr_pkg::fdr_cmd_t                cmd,
   input  wire logic [fdr_pkg::NUM_GROUPS-1:0]   cmd_groups,
   input  wire logic                             cmd_size_given,
   input  wire logic [fdr_pkg::SIZE_W-1:0]       cmd_size,
   input  wire logic                             cmd_addr_given,
   input  wire logic [fdr_pkg::ADDR_W-1:0]       cmd_addr,
   input  wire logic                             route_change,
   input  wire logic [11:0]                      group_chans,
   input  wire logic                             arm_acquisition,
   input  wire logic                             continuous_acquisition,
   input  wire logic [fdr_pkg::NUM_GROUPS-1:0]   meas_complete,
   input  wire logic [fdr_pkg::NUM_GROUPS-1:0]   block_acquired,
   input  wire logic [fdr_pkg::NUM_GROUPS-1:0]   xfer_done,
   input  wire logic                             ovr_flag_en,
   input  wire logic [fdr_pkg::NUM_GROUPS-1:0]   ovr_near,
   input  wire logic                             route_set,
   input  wire logic                             route_to_fdc,
   input  wire logic [1:0]                       query_group,
   output logic      [fdr_pkg::NUM_GROUPS-1:0]   xfer_req,
   output logic      [4*fdr_pkg::SIZE_W-1:0]     req_size,
   output logic      [4*(fdr_pkg::SIZE_W+1)-1:0] req_bytes,
   output logic      [4*fdr_pkg::ADDR_W-1:0]     req_addr,
   output logic      [4*fdr_pkg::SIZE_W-1:0]     req_per_chan,
   output logic      [fdr_pkg::NUM_GROUPS-1:0]   acq_halt,
   output logic      [fdr_pkg::NUM_GROUPS-1:0]   lsb_mark,
   output logic                                  cmd_error,
   output logic                                  resp_to_fdc,
   output logic      [2:0]                       resp_chan,
   output fdr_pkg::fdr_state_t                   q_state,
   output logic      [fdr_pkg::SIZE_W-1:0]       q_size,
   output logic      [fdr_pkg::ADDR_W-1:0]       q_addr,
   output logic      [fdr_pkg::QCNT_W-1:0]       q_count
);
   import fdr_pkg::*;

   // Per-group configuration and state
   fdr_state_t                  st_q   [NUM_GROUPS];
   logic [SIZE_W-1:0]           size_q [NUM_GROUPS];
   logic signed [ADDR_W-1:0]    addr_q [NUM_GROUPS];
   logic signed [ADDR_W-1:0]    next_q [NUM_GROUPS];
   logic [QCNT_W-1:0]           cnt_q  [NUM_GROUPS];
   logic [NUM_GROUPS-1:0]       first_q;
   logic [NUM_GROUPS-1:0]       armed_q;
   logic [NUM_GROUPS-1:0]       mc_prev_q;

   // Channel count per group, decoded from a 3-bit field
   function automatic logic [2:0] chan_count(input logic [2:0] f);
      chan_count = (f == 3'h0) ? 3'h1 : f;
   endfunction

   logic [SIZE_W-1:0]        eff_size;
   logic signed [ADDR_W-1:0] eff_addr;
   // R18: omitted parameters take defaults
   assign eff_size = cmd_size_given ? cmd_size : SIZE_DEFAULT;
   assign eff_addr = cmd_addr_given ? cmd_addr : ADDR_DEFAULT;

   // R20: group g serves hardware channel g
   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : grp
         logic [SIZE_W-1:0]        rsize;
         logic signed [ADDR_W-1:0] raddr;
         logic                     sel;
         logic                     mc_rise;
         logic                     blk_evt;
         logic                     push;
         logic                     pop;
         logic                     full;
         assign sel     = cmd_groups[g];
         assign mc_rise = meas_complete[g] && !mc_prev_q[g];
         // R9: continuous mode counts blocks, single shot counts completion
         assign blk_evt = (st_q[g] == FDR_ST_AUT) && armed_q[g] &&
                          (continuous_acquisition ? block_acquired[g] : mc_rise);
         assign full    = (cnt_q[g] == QCNT_W'(QDEPTH));
         assign push    = blk_evt && !full;
         assign pop     = xfer_done[g] && (cnt_q[g] != '0);

         fdr_round u_round (
            .auto_mode    (cmd == FDR_CMD_AUTO),
            .size_in      (eff_size),
            .addr_in      (eff_addr),
            .active_chans (chan_count(group_chans[3*g +: 3])),
            .size_out     (rsize),
            .addr_out     (raddr),
            .per_chan     ()
         );

         // Mode and parameter registers
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               st_q[g]   <= FDR_ST_OFF;
               size_q[g] <= SIZE_DEFAULT;
               addr_q[g] <= ADDR_DEFAULT;
            end else if (route_change) begin
               // R19: routing restores full size, zero address
               size_q[g] <= SIZE_MAX;
               addr_q[g] <= ADDR_DEFAULT;
            end else if (sel && cmd == FDR_CMD_OFF) begin
               // R14: off clears both modes
               st_q[g] <= FDR_ST_OFF;
            end else if (sel && cmd == FDR_CMD_IMM && st_q[g] != FDR_ST_AUT) begin
               // R5: immediate takes rounded address, size as given
               st_q[g]   <= FDR_ST_IMM;
               size_q[g] <= rsize;
               addr_q[g] <= raddr;
            end else if (sel && cmd == FDR_CMD_AUTO) begin
               // R13: stored size is already rounded
               st_q[g]   <= FDR_ST_AUT;
               size_q[g] <= rsize;
               addr_q[g] <= raddr;
            end else if (st_q[g] == FDR_ST_IMM && xfer_done[g] && cnt_q[g] == QCNT_W'(1)) begin
               // R7: immediate state ends with its transfer
               st_q[g] <= FDR_ST_OFF;
            end
         end

         // Arming and edge history
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               armed_q[g]   <= 1'b0;
               mc_prev_q[g] <= 1'b0;
            end else begin
               mc_prev_q[g] <= meas_complete[g];
               // R8: auto requests wait for arming
               if (arm_acquisition) begin
                  armed_q[g] <= 1'b1;
               end else if (st_q[g] != FDR_ST_AUT) begin
                  armed_q[g] <= 1'b0;
               end
            end
         end

         // Buffer queue count, push and pop in one cycle both counted; a block arriving while full is dropped even with a pop
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               cnt_q[g] <= '0;
            end else if (sel && cmd == FDR_CMD_OFF) begin
               cnt_q[g] <= '0;
            end else if (sel && cmd == FDR_CMD_IMM && st_q[g] != FDR_ST_AUT) begin
               cnt_q[g] <= cnt_q[g] + QCNT_W'(!pop);
            end else begin
               // R21: pop on completion, next request follows
               cnt_q[g] <= cnt_q[g] + QCNT_W'(push) - QCNT_W'(pop);
            end
         end

         // Request address tracking
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               next_q[g]  <= ADDR_DEFAULT;
               first_q[g] <= 1'b1;
            end else if (arm_acquisition || (sel && cmd != FDR_CMD_NONE)) begin
               first_q[g] <= 1'b1;
               next_q[g]  <= (continuous_acquisition) ? ADDR_DEFAULT : raddr;
            end else if (pop) begin
               // R12: advance one block per request in continuous mode
               if (continuous_acquisition && st_q[g] == FDR_ST_AUT) begin
                  next_q[g] <= next_q[g] + ADDR_W'(size_q[g]);
               end
               first_q[g] <= 1'b0;
            end
         end

         // Request outputs, all registered
         always_ff @(posedge ref_clk) begin
            if (!rstn) begin
               xfer_req[g]                         <= 1'b0;
               req_size[g*SIZE_W +: SIZE_W]        <= '0;
               req_bytes[g*(SIZE_W+1) +: SIZE_W+1] <= '0;
               req_addr[g*ADDR_W +: ADDR_W]        <= '0;
               req_per_chan[g*SIZE_W +: SIZE_W]    <= '0;
               acq_halt[g]                         <= 1'b0;
               lsb_mark[g]                         <= 1'b0;
            end else begin
               // R21: request held while anything queued
               xfer_req[g] <= (cnt_q[g] + QCNT_W'(push) - QCNT_W'(pop)) != '0;
               req_size[g*SIZE_W +: SIZE_W] <= size_q[g];
               // R1: bytes are two per sample
               req_bytes[g*(SIZE_W+1) +: SIZE_W+1] <= {size_q[g], 1'b0};
               // R3: signed offset from trigger; R12: continuous uses tracker
               req_addr[g*ADDR_W +: ADDR_W] <=
                  (continuous_acquisition && st_q[g] == FDR_ST_AUT) ? next_q[g] : addr_q[g];
               // R2: per-channel share
               req_per_chan[g*SIZE_W +: SIZE_W] <=
                  size_q[g] >> ((chan_count(group_chans[3*g +: 3]) == 3'h4) ? 2 :
                                (chan_count(group_chans[3*g +: 3]) == 3'h2) ? 1 : 0);
               // R10: halt in continuous mode while every buffer is taken
               acq_halt[g] <= continuous_acquisition && (cnt_q[g] + QCNT_W'(push)
                              - QCNT_W'(pop)) >= QCNT_W'(QDEPTH);
               // R11: mark LSB only with flagging enabled
               lsb_mark[g] <= ovr_flag_en && ovr_near[g];
            end
         end
      end
   endgenerate

   // R6: immediate while automatic is refused with error
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cmd_error <= 1'b0;
      end else begin
         cmd_error <= 1'b0;
         for (int i = 0; i < NUM_GROUPS; i++) begin
            if (cmd == FDR_CMD_IMM && cmd_groups[i] && st_q[i] == FDR_ST_AUT) begin
               cmd_error <= 1'b1;
            end
         end
      end
   end

   // R16: response route changes at once
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         resp_to_fdc <= 1'b0;
         resp_chan   <= 3'h0;
      end else if (route_set) begin
         resp_to_fdc <= route_to_fdc;
         resp_chan   <= route_to_fdc ? RESP_CHAN_SW : 3'h0;
      end
   end

   // R15: query fields; R17: queue count
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q_state <= FDR_ST_OFF;
         q_size  <= '0;
         q_addr  <= '0;
         q_count <= '0;
      end else begin
         q_state <= st_q[query_group];
         q_size  <= size_q[query_group];
         q_addr  <= addr_q[query_group];
         q_count <= cnt_q[query_group];
      end
   end

   // Checks
   immediate_refused_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R6
      (cmd == FDR_CMD_IMM && cmd_groups[1] && st_q[1] == FDR_ST_AUT) |=> cmd_error)
      else $error("immediate in auto not flagged");
   off_clears_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R14
      (cmd == FDR_CMD_OFF && cmd_groups[1] && !route_change) |=> st_q[1] == FDR_ST_OFF)
      else $error("off did not clear group");
   byte_double_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
      $past(rstn) |-> req_bytes[SIZE_W:0] == {$past(size_q[0]), 1'b0})
      else $error("byte length not doubled");
   route_resets_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R19
      route_change |=> (size_q[1] == SIZE_MAX && addr_q[1] == ADDR_DEFAULT))
      else $error("routing did not reset buffer");
   resp_route_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R16
      (route_set && route_to_fdc) |=> (resp_to_fdc && resp_chan == RESP_CHAN_SW))
      else $error("response route not switched");
   lsb_gate_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R11
      !ovr_flag_en |=> !lsb_mark[3])
      else $error("lsb marked while disabled");
   req_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R21
      (cnt_q[2] != '0 && !xfer_done[2]) |=> xfer_req[2])
      else $error("request dropped with queue");
   auto_size_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R13
      (cmd == FDR_CMD_AUTO && cmd_groups[1] && !route_change) |=>
      (size_q[1] >= SIZE_AUTO_MIN && (size_q[1] & (size_q[1] - 1'b1)) == '0))
      else $error("auto size not power of two");
   halt_full_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R10
      (continuous_acquisition && cnt_q[0] == QCNT_W'(QDEPTH) && !xfer_done[0]) |=> acq_halt[0])
      else $error("acquisition not halted");
   first_at_trigger_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R12
      (first_q[0] && continuous_acquisition && st_q[0] == FDR_ST_AUT) |-> next_q[0] == ADDR_DEFAULT)
      else $error("first continuous request not at trigger");
   imm_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
      cmd == FDR_CMD_IMM ##[1:4] xfer_req[0]);
   auto_cov: cover property (@(posedge ref_clk) disable iff (!rstn)
      st_q[1] == FDR_ST_AUT && meas_complete[1] ##[1:4] xfer_req[1]);
   halt_cov: cover property (@(posedge ref_clk) disable iff (!rstn) acq_halt[0]);
endmodule
`default_nettype wire

// File: hw/fdr_pkg.sv
package fdr_pkg;
   localparam int NUM_GROUPS     = 4;
   localparam int SIZE_W         = 19;
   localparam int ADDR_W         = 20;
   localparam int QCNT_W         = 5;
   // Mode command encodings
   typedef enum logic [1:0] {FDR_CMD_OFF, FDR_CMD_IMM, FDR_CMD_AUTO, FDR_CMD_NONE} fdr_cmd_t;
   // Reported group state
   typedef enum logic [1:0] {FDR_ST_OFF, FDR_ST_IMM, FDR_ST_AUT} fdr_state_t;
   localparam logic [SIZE_W-1:0] SIZE_DEFAULT  = 19'h04000;  // 16384 samples
   localparam logic [SIZE_W-1:0] SIZE_AUTO_MIN = 19'h00800;  // 2048
   localparam logic [SIZE_W-1:0] SIZE_AUTO_MAX = 19'h40000;  // 262144
   localparam logic [SIZE_W-1:0] SIZE_MAX      = 19'h40000;  // Full buffer after routing
   localparam logic [ADDR_W-1:0] ADDR_DEFAULT  = 20'h00000;  // Trigger location
   localparam logic [3:0]        HW_LIST_DEFAULT = 4'h1;
   localparam int                QUEUE_DEPTH   = 16;
   localparam int                OVR_MARK_SAMPLES = 4;
   localparam logic [2:0]        RESP_CHAN_SW  = 3'h4;       // Software channel number
endpackage

// File: hw/fdr_round.sv
`timescale 1ns/10ps
`default_nettype none
// Size and address rounding for one group
module fdr_round
   import fdr_pkg::*;
(
   input  wire logic                         auto_mode,
   input  wire logic [fdr_pkg::SIZE_W-1:0]   size_in,
   input  wire logic signed [fdr_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [2:0]                   active_chans,
   output logic      [fdr_pkg::SIZE_W-1:0]   size_out,
   output logic signed [fdr_pkg::ADDR_W-1:0] addr_out,
   output logic      [fdr_pkg::SIZE_W-1:0]   per_chan
);
   // R13: power-of-two size in auto mode
   always_comb begin
      size_out = size_in;
      if (auto_mode) begin
         size_out = SIZE_AUTO_MAX;
         for (int i = 17; i >= 11; i--) begin
            if (size_in <= (SIZE_W'(1) << i)) begin
               size_out = SIZE_W'(1) << i;
            end
         end
      end
   end
   // R4: address resolution by active channel count
   always_comb begin
      case (active_chans)
         3'h1:    addr_out = {addr_in[ADDR_W-1:2], 2'b00};
         3'h2:    addr_out = {addr_in[ADDR_W-1:1], 1'b0};
         default: addr_out = addr_in;
      endcase
   end
   // R2: even split for two or four active channels
   always_comb begin
      case (active_chans)
         3'h2:    per_chan = size_out >> 1;
         3'h4:    per_chan = size_out >> 2;
         default: per_chan = size_out;
      endcase
   end
endmodule
`default_nettype wire

// File: testbench/fdr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Bus controller side: completes each pending request after a delay
module fdr_host_model
   import fdr_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic       hold,
   input  wire logic [7:0] delay,
   input  wire logic [3:0] xfer_req,
   output logic      [3:0] xfer_done
);
   int cnt [4];
   // drain one buffer per pulse
   // Guard after a pulse so a standing request is not completed twice
   always @(negedge ref_clk) begin
      for (int g = 0; g < 4; g++) begin
         xfer_done[g] <= 1'b0;
         if (!rstn) cnt[g] = 0;
         else if (cnt[g] < 0) cnt[g]++;
         else if (hold || !xfer_req[g]) cnt[g] = 0;
         else if (cnt[g] >= int'(delay)) begin
            xfer_done[g] <= 1'b1;
            cnt[g] = -4;
         end else cnt[g]++;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import fdr_pkg::*;
   logic                ref_clk, rstn, cmd_size_given, cmd_addr_given, route_change;
   logic                arm_acquisition, continuous_acquisition, ovr_flag_en, route_set;
   logic                route_to_fdc, hold, cmd_error, resp_to_fdc;
   fdr_cmd_t            cmd;
   logic [3:0]          cmd_groups, meas_complete, block_acquired, xfer_done, ovr_near;
   logic [3:0]          xfer_req, acq_halt, lsb_mark;
   logic [18:0]         cmd_size, q_size;
   logic [19:0]         cmd_addr, q_addr;
   logic [11:0]         group_chans;
   logic [1:0]          query_group;
   logic [75:0]         req_size, req_per_chan;
   logic [79:0]         req_bytes, req_addr;
   logic [2:0]          resp_chan;
   fdr_state_t          q_state;
   logic [4:0]          q_count;
   int                  n_mismatch = 0;
   int                  n_checks = 0;
   logic [18:0]         asz [3] = '{19'h00064, 19'h00BB8, 19'h40000};
   logic [18:0]         aex [3] = '{19'h00800, 19'h01000, 19'h40000};
   logic [2:0]          chs [3] = '{3'h1, 3'h2, 3'h4};
   logic [19:0]         aexp [3] = '{20'hFFFF8, 20'hFFFFA, 20'hFFFFB};

   fdr_requester uut (.ref_clk, .rstn, .cmd, .cmd_groups, .cmd_size_given, .cmd_size,
      .cmd_addr_given, .cmd_addr, .route_change, .group_chans, .arm_acquisition,
      .continuous_acquisition, .meas_complete, .block_acquired, .xfer_done, .ovr_flag_en,
      .ovr_near, .route_set, .route_to_fdc, .query_group, .xfer_req, .req_size, .req_bytes,
      .req_addr, .req_per_chan, .acq_halt, .lsb_mark, .cmd_error, .resp_to_fdc, .resp_chan,
      .q_state, .q_size, .q_addr, .q_count);
   fdr_host_model host (.ref_clk, .rstn, .hold, .delay(8'h08), .xfer_req, .xfer_done);

   // Free-running 200 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // One command, present for a single cycle
   task automatic issue(input fdr_cmd_t c, input logic [3:0] g, input logic sg,
                        input logic [18:0] s, input logic ag, input logic [19:0] a);
      cmd = c; cmd_groups = g; cmd_size_given = sg;
      cmd_size = s; cmd_addr_given = ag; cmd_addr = a;
      cyc(1);
      cmd = FDR_CMD_NONE; cmd_size_given = 1'b0; cmd_addr_given = 1'b0;
   endtask

   // Bounded waits on a request line and on the queue count
   task automatic wrq(input int g, input logic v);
      int i;
      i = 0;
      while (xfer_req[g] !== v && i < 600) begin cyc(1); i++; end
      chk(xfer_req[g], v);
   endtask

   task automatic wq(input logic [4:0] n);
      int i;
      i = 0;
      while (q_count !== n && i < 600) begin cyc(1); i++; end
      chk(q_count, n);
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #100000;
      n_mismatch++;
      wrap_up();
   end

   initial begin
      rstn = 1'b0; cmd = FDR_CMD_NONE; cmd_groups = '0; cmd_size_given = 1'b0;
      cmd_size = '0; cmd_addr_given = 1'b0; cmd_addr = '0; route_change = 1'b0;
      group_chans = 12'h080; arm_acquisition = 1'b0; continuous_acquisition = 1'b0;
      meas_complete = '0; block_acquired = '0; ovr_flag_en = 1'b0; ovr_near = '0;
      route_set = 1'b0; route_to_fdc = 1'b0; query_group = 2'h2; hold = 1'b1;
      cyc(16);
      rstn = 1'b1;
      cyc(2);
      chk(xfer_req, 4'h0);
      chk(q_state, FDR_ST_OFF);
      // Immediate request on the third group, two channels active
      issue(FDR_CMD_IMM, 4'h4, 1'b1, 19'h00064, 1'b1, 20'h00007);
      cyc(2);
      chk(q_state, FDR_ST_IMM);
      wrq(2, 1'b1);
      chk(xfer_req, 4'h4);
      chk(req_size[38 +: 19], 19'h00064);
      chk(req_bytes[40 +: 20], 20'h000C8);
      chk(req_per_chan[38 +: 19], 19'h00032);
      chk(req_addr[40 +: 20], 20'h00006);
      chk(q_addr, 20'h00006);
      hold = 1'b0;
      wrq(2, 1'b0);
      cyc(2);
      chk(q_state, FDR_ST_OFF);
      // Negative offsets round toward earlier samples
      query_group = 2'h0;
      for (int i = 0; i < 3; i++) begin
         group_chans = {9'h000, chs[i]};
         issue(FDR_CMD_IMM, 4'h1, 1'b1, 19'h00040, 1'b1, 20'hFFFFB);
         wrq(0, 1'b1);
         chk(req_addr[0 +: 20], aexp[i]);
         wrq(0, 1'b0);
      end
      issue(FDR_CMD_IMM, 4'h1, 1'b0, 19'h00000, 1'b0, 20'h00000);
      cyc(2);
      chk(q_size, SIZE_DEFAULT);
      chk(q_addr, 20'h00000);
      wrq(0, 1'b0);
      // Automatic mode on the second group
      query_group = 2'h1;
      hold = 1'b1;
      for (int i = 0; i < 3; i++) begin
         issue(FDR_CMD_AUTO, 4'h2, 1'b1, asz[i], 1'b0, 20'h00000);
         cyc(2);
         chk(q_state, FDR_ST_AUT);
         chk(q_size, aex[i]);
      end
      issue(FDR_CMD_IMM, 4'h2, 1'b1, 19'h00040, 1'b0, 20'h00000);
      chk(cmd_error, 1'b1);
      cyc(2);
      chk(q_state, FDR_ST_AUT);
      arm_acquisition = 1'b1;
      cyc(1);
      arm_acquisition = 1'b0;
      meas_complete = 4'h2;
      wrq(1, 1'b1);
      issue(FDR_CMD_OFF, 4'h2, 1'b0, 19'h00000, 1'b0, 20'h00000);
      cyc(2);
      chk(q_state, FDR_ST_OFF);
      meas_complete = 4'h0;
      hold = 1'b0;
      wrq(1, 1'b0);
      // Continuous capture fills the queue while the host stalls
      query_group = 2'h0;
      group_chans = 12'h001;
      hold = 1'b1;
      issue(FDR_CMD_AUTO, 4'h1, 1'b1, 19'h00800, 1'b0, 20'h00000);
      continuous_acquisition = 1'b1;
      arm_acquisition = 1'b1;
      cyc(1);
      arm_acquisition = 1'b0;
      for (int i = 0; i < QUEUE_DEPTH; i++) begin
         block_acquired = 4'h1;
         cyc(1);
         block_acquired = 4'h0;
         cyc(1);
      end
      cyc(2);
      chk(q_count, 5'h10);
      chk(req_addr[0 +: 20], 20'h00000);
      chk(acq_halt[0], 1'b1);
      hold = 1'b0;
      wq(5'h0F);
      cyc(2);
      chk(req_addr[0 +: 20], 20'h00800);
      chk(acq_halt[0], 1'b0);
      wq(5'h00);
      chk(xfer_req, 4'h0);
      continuous_acquisition = 1'b0;
      // Overrun marking follows the enable
      ovr_flag_en = 1'b1;
      ovr_near = 4'h8;
      cyc(2);
      chk(lsb_mark, 4'h8);
      ovr_flag_en = 1'b0;
      cyc(2);
      chk(lsb_mark, 4'h0);
      ovr_near = 4'h0;
      // Response steering takes effect on the next edge
      for (int i = 1; i >= 0; i--) begin
         route_to_fdc = i[0];
         route_set = 1'b1;
         cyc(1);
         route_set = 1'b0;
         chk(resp_to_fdc, i[0]);
         chk(resp_chan, i[0] ? RESP_CHAN_SW : 3'h0);
      end
      // Channel routing change restores full buffers at the trigger
      query_group = 2'h2;
      route_change = 1'b1;
      cyc(1);
      route_change = 1'b0;
      cyc(2);
      chk(q_size, SIZE_MAX);
      chk(q_addr, 20'h00000);
      wrap_up();
   end
endmodule
`default_nettype wire
